// ===== rtl/ddr_timing_pkg.sv
package ddr_timing_pkg;

   // Register offsets (byte addresses)
   localparam logic [7:0] TIM_ONE_OFFSET = 8'h00;
   localparam logic [7:0] STATUS_OFFSET = 8'h04;

   // Field positions of the timing register
   localparam int RSVD_LSB = 30;
   localparam int WR_MSB = 29;
   localparam int WR_LSB = 25;
   localparam int RAS_MSB = 24;
   localparam int RAS_LSB = 18;
   localparam int RC_MSB = 17;
   localparam int RC_LSB = 10;
   localparam int RRD_MSB = 9;
   localparam int RRD_LSB = 4;
   localparam int WTR_MSB = 3;
   localparam int WTR_LSB = 0;

   // Field reset values
   localparam logic [1:0] RSVD_VALUE = 2'h0;
   localparam logic [4:0] WR_RESET = 5'h1F;
   localparam logic [6:0] RAS_RESET = 7'h7F;
   localparam logic [7:0] RC_RESET = 8'hFF;
   localparam logic [5:0] RRD_RESET = 6'h3F;
   localparam logic [3:0] WTR_RESET = 4'hF;
   localparam logic [31:0] TIM_ONE_RESET =
      {RSVD_VALUE, WR_RESET, RAS_RESET, RC_RESET, RRD_RESET, WTR_RESET};
   localparam logic [31:0] TIM_ONE_WMASK = 32'h3FFF_FFFF;

   // Status register layout
   localparam int STAT_RRD_BIT = 0;
   localparam int STAT_WTR_BIT = 1;
   localparam int STAT_BANK_LSB = 8;

   // Width of a spacing counter, fits the widest field
   localparam int SPACE_W = 8;

   // Commands offered by the scheduler
   typedef enum logic [1:0] {
      CMD_ACTIVATE = 2'b00,
      CMD_PRECHARGE = 2'b01,
      CMD_READ = 2'b10,
      CMD_WRITE = 2'b11
   } mem_cmd_t;

endpackage

// ===== rtl/spacing_if.sv
// Load and status lines of one spacing counter
interface spacing_if;
   import ddr_timing_pkg::*;
   logic load;
   logic [SPACE_W-1:0] value;
   logic tick;
   logic done;
   modport owner (output load, output value, output tick, input done);
   modport counter (input load, input value, input tick, output done);
endinterface

// ===== rtl/spacing_counter.sv
module spacing_counter
   import ddr_timing_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Load and status
   spacing_if.counter sp
);

   logic [SPACE_W-1:0] count_reg;
   logic [SPACE_W-1:0] count_next;

   // Load latches the value, later register writes do not touch it
   always_comb begin
      count_next = count_reg;
      if (sp.load) begin
         count_next = sp.value;
      end else if (sp.tick && count_reg != '0) begin
         count_next = count_reg - 1'b1;
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         count_reg <= '0;
      end else begin
         count_reg <= count_next;
      end
   end

   // Issuing tick only loads and does not count, so the next command waits value plus one ticks
   assign sp.done = (count_reg == '0);

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_load_value: assert property (sp.load |=> count_reg == $past(sp.value))
      else $error("spacing counter did not take loaded value");
   a_hold_count: assert property (!sp.load && !sp.tick |=> $stable(count_reg))
      else $error("spacing counter moved without a tick");
   a_tick_step: assert property (!sp.load && sp.tick && !sp.done
      |=> count_reg == $past(count_reg) - 1'b1)
      else $error("spacing counter missed a tick");

endmodule // spacing_counter

// ===== rtl/ddr_timing_one.sv
// Operation
// - Top two bits read zero, writes ignored
// - Write to precharge waits write-recovery plus one
// - Activate to precharge waits field plus one
// - Same-bank activates spaced field plus one
// - Other-bank activates spaced field plus one
// - Write to read waits field plus one
// - Spacing counted in memory clock periods
//
// The implementer's own choices: the Wishbone slave port and the register addresses.
module ddr_timing_one
   import ddr_timing_pkg::*;
#(
   parameter int NUM_BANKS = 8,
   parameter int BANK_W = 3,
   parameter int ADDR_W = 8
) (
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [ADDR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Memory clock as driven to the memories
   input wire logic memory_clock_i,
   // Command request from the scheduler
   input wire logic cmd_valid_i,
   input wire mem_cmd_t cmd_type_i,
   input wire logic [BANK_W-1:0] cmd_bank_i,
   // Command issued to the memories
   output logic cmd_issue_o,
   output mem_cmd_t cmd_type_o,
   output logic [BANK_W-1:0] cmd_bank_o
);

   // Bus side state
   logic [31:0] timing_reg;
   logic [31:0] timing_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   logic ack_reg;
   logic ack_next;
   logic [31:0] status_word;

   // Memory clock edge finder
   logic mclk_meta_reg;
   logic mclk_sync_reg;
   logic mclk_prev_reg;
   logic tick;

   // Command side state
   logic issue_reg;
   logic issue_next;
   mem_cmd_t type_reg;
   mem_cmd_t type_next;
   logic [BANK_W-1:0] bank_reg;
   logic [BANK_W-1:0] bank_next;
   logic [BANK_W-1:0] last_act_reg;
   logic [BANK_W-1:0] last_act_next;
   logic act_seen_reg;
   logic act_seen_next;
   logic permit;
   logic go;

   // Field values, widened to counter width
   logic [SPACE_W-1:0] wr_val;
   logic [SPACE_W-1:0] ras_val;
   logic [SPACE_W-1:0] rc_val;
   logic [SPACE_W-1:0] rrd_val;
   logic [SPACE_W-1:0] wtr_val;

   // Counter status
   logic [NUM_BANKS-1:0] wr_done;
   logic [NUM_BANKS-1:0] ras_done;
   logic [NUM_BANKS-1:0] rc_done;
   logic rrd_done;
   logic wtr_done;

   assign wr_val = SPACE_W'(timing_reg[WR_MSB:WR_LSB]);
   assign ras_val = SPACE_W'(timing_reg[RAS_MSB:RAS_LSB]);
   assign rc_val = SPACE_W'(timing_reg[RC_MSB:RC_LSB]);
   assign rrd_val = SPACE_W'(timing_reg[RRD_MSB:RRD_LSB]);
   assign wtr_val = timing_reg[WTR_MSB:WTR_LSB] == '0 ? '0
                  : SPACE_W'(timing_reg[WTR_MSB:WTR_LSB]);

   // Status: pending precharge spacings (write recovery, activate to precharge) per bank, shared spacings globally
   always_comb begin
      status_word = '0;
      status_word[STAT_RRD_BIT] = ~rrd_done;
      status_word[STAT_WTR_BIT] = ~wtr_done;
      status_word[STAT_BANK_LSB +: NUM_BANKS] = ~(wr_done & ras_done);
   end

   // Register writes, reads and single-cycle acknowledge
   always_comb begin
      timing_next = timing_reg;
      rdata_next = rdata_reg;
      ack_next = wb_cyc_i && wb_stb_i && !ack_reg;
      if (ack_next) begin
         rdata_next = '0;
         if (wb_adr_i == ADDR_W'(TIM_ONE_OFFSET)) begin
            rdata_next = timing_reg;
            if (wb_we_i) begin
               for (int i = 0; i < 4; i++) begin
                  if (wb_sel_i[i]) begin
                     timing_next[8*i +: 8] = wb_dat_i[8*i +: 8];
                  end
               end
               timing_next = timing_next & TIM_ONE_WMASK;
            end
         end else if (wb_adr_i == ADDR_W'(STATUS_OFFSET)) begin
            rdata_next = status_word;
         end else begin
            rdata_next = '0;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         timing_reg <= TIM_ONE_RESET;
         rdata_reg <= '0;
         ack_reg <= 1'b0;
      end else begin
         timing_reg <= timing_next;
         rdata_reg <= rdata_next;
         ack_reg <= ack_next;
      end
   end

   assign wb_dat_o = rdata_reg;
   assign wb_ack_o = ack_reg;

   // Two-stage sync of the memory clock, then rising edge detect
   // Chain keeps sampling in reset, so release shows no false edge
   always_ff @(posedge clk_i) begin
      mclk_meta_reg <= memory_clock_i;
      mclk_sync_reg <= mclk_meta_reg;
      mclk_prev_reg <= mclk_sync_reg;
   end

   assign tick = mclk_sync_reg && !mclk_prev_reg;

   // Permission by command kind
   always_comb begin
      case (cmd_type_i)
         CMD_ACTIVATE: begin
            permit = rc_done[cmd_bank_i]
               && (rrd_done || !act_seen_reg || cmd_bank_i == last_act_reg);
         end
         CMD_PRECHARGE: begin
            permit = ras_done[cmd_bank_i] && wr_done[cmd_bank_i];
         end
         CMD_READ: begin
            permit = wtr_done;
         end
         default: begin
            permit = 1'b1;
         end
      endcase
   end

   // Issue only on a memory clock edge
   assign go = cmd_valid_i && tick && !issue_reg && permit;

   always_comb begin
      issue_next = go;
      type_next = type_reg;
      bank_next = bank_reg;
      last_act_next = last_act_reg;
      act_seen_next = act_seen_reg;
      if (go) begin
         type_next = cmd_type_i;
         bank_next = cmd_bank_i;
         if (cmd_type_i == CMD_ACTIVATE) begin
            last_act_next = cmd_bank_i;
            act_seen_next = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         issue_reg <= 1'b0;
         type_reg <= CMD_ACTIVATE;
         bank_reg <= '0;
         last_act_reg <= '0;
         act_seen_reg <= 1'b0;
      end else begin
         issue_reg <= issue_next;
         type_reg <= type_next;
         bank_reg <= bank_next;
         last_act_reg <= last_act_next;
         act_seen_reg <= act_seen_next;
      end
   end

   assign cmd_issue_o = issue_reg;
   assign cmd_type_o = type_reg;
   assign cmd_bank_o = bank_reg;

   // Per-bank spacing counters
   genvar b;
   generate
      for (b = 0; b < NUM_BANKS; b++) begin : g_bank
         spacing_if wr_sp ();
         spacing_if ras_sp ();
         spacing_if rc_sp ();
         logic hit;
         assign hit = go && cmd_bank_i == BANK_W'(b);
         // Write recovery before precharge
         assign wr_sp.load = hit && cmd_type_i == CMD_WRITE;
         assign wr_sp.value = wr_val;
         assign wr_sp.tick = tick;
         assign wr_done[b] = wr_sp.done;
         // Activate to precharge
         assign ras_sp.load = hit && cmd_type_i == CMD_ACTIVATE;
         assign ras_sp.value = ras_val;
         assign ras_sp.tick = tick;
         assign ras_done[b] = ras_sp.done;
         // Activate to activate, same bank
         assign rc_sp.load = hit && cmd_type_i == CMD_ACTIVATE;
         assign rc_sp.value = rc_val;
         assign rc_sp.tick = tick;
         assign rc_done[b] = rc_sp.done;
         spacing_counter u_wr (.clk_i(clk_i), .rst_i(rst_i), .sp(wr_sp));
         spacing_counter u_ras (.clk_i(clk_i), .rst_i(rst_i), .sp(ras_sp));
         spacing_counter u_rc (.clk_i(clk_i), .rst_i(rst_i), .sp(rc_sp));
      end
   endgenerate

   // Shared counters: other-bank activate and write to read
   spacing_if rrd_sp ();
   spacing_if wtr_sp ();
   assign rrd_sp.load = go && cmd_type_i == CMD_ACTIVATE;
   assign rrd_sp.value = rrd_val;
   assign rrd_sp.tick = tick;
   assign rrd_done = rrd_sp.done;
   assign wtr_sp.load = go && cmd_type_i == CMD_WRITE;
   assign wtr_sp.value = wtr_val;
   assign wtr_sp.tick = tick;
   assign wtr_done = wtr_sp.done;
   spacing_counter u_rrd (.clk_i(clk_i), .rst_i(rst_i), .sp(rrd_sp));
   spacing_counter u_wtr (.clk_i(clk_i), .rst_i(rst_i), .sp(wtr_sp));

   // Ticks since the last write, saturating, for an independent check
   logic [8:0] since_wr_reg;
   logic [8:0] since_wr_next;
   logic wr_seen_reg;
   logic [SPACE_W-1:0] wr_gap_reg;
   logic [SPACE_W-1:0] wr_gap_next;
   always_comb begin
      since_wr_next = since_wr_reg;
      wr_gap_next = wr_gap_reg;
      if (wtr_sp.load) begin
         since_wr_next = '0;
         wr_gap_next = wtr_val; // Spacing the write started with
      end else if (tick && since_wr_reg != 9'h1FF) begin
         since_wr_next = since_wr_reg + 1'b1;
      end
   end
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         since_wr_reg <= '0;
         wr_seen_reg <= 1'b0;
         wr_gap_reg <= '0;
      end else begin
         since_wr_reg <= since_wr_next;
         wr_gap_reg <= wr_gap_next;
         wr_seen_reg <= wr_seen_reg || wtr_sp.load;
      end
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_reserved_read: assert property (wb_ack_o |-> wb_dat_o[31:30] == 2'h0)
      else $error("reserved bits read nonzero");
   a_reserved_kept: assert property (timing_reg[31:RSVD_LSB] == RSVD_VALUE)
      else $error("reserved bits stored a written value");
   a_reset_value: assert property ($past(rst_i) |-> timing_reg == TIM_ONE_RESET)
      else $error("timing register reset value wrong");
   a_write_precharge: assert property (go && cmd_type_i == CMD_PRECHARGE
      |-> wr_done[cmd_bank_i])
      else $error("precharge issued inside write recovery");
   a_act_precharge: assert property (go && cmd_type_i == CMD_PRECHARGE
      |-> ras_done[cmd_bank_i])
      else $error("precharge issued too soon after activate");
   a_same_bank_act: assert property (go && cmd_type_i == CMD_ACTIVATE
      |-> rc_done[cmd_bank_i])
      else $error("same-bank activates too close");
   a_other_bank_act: assert property (go && cmd_type_i == CMD_ACTIVATE && act_seen_reg
      && cmd_bank_i != last_act_reg |-> rrd_done)
      else $error("other-bank activates too close");
   a_write_read: assert property (tick && go && cmd_type_i == CMD_READ && wr_seen_reg
      |-> since_wr_reg >= 9'(wr_gap_reg))
      else $error("read issued too soon after write");
   a_tick_issue: assert property (cmd_issue_o |-> $past(tick))
      else $error("command issued off a memory clock edge");
   a_issue_pulse: assert property (cmd_issue_o |=> !cmd_issue_o [*2])
      else $error("command issue longer than one cycle");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("acknowledge held more than one cycle");

   c_activate: cover property (cmd_issue_o && cmd_type_o == CMD_ACTIVATE);
   c_precharge: cover property (cmd_issue_o && cmd_type_o == CMD_PRECHARGE);
   c_read_after_write: cover property (go && cmd_type_i == CMD_READ && wr_seen_reg);
   c_timing_write: cover property (ack_next && wb_we_i
      && wb_adr_i == ADDR_W'(TIM_ONE_OFFSET));

endmodule // ddr_timing_one

// ===== verification/ddr_memory_model.sv
module ddr_memory_model
   import ddr_timing_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // Issued command and the timing software programmed
   input wire logic cmd_issue_i,
   input wire mem_cmd_t cmd_type_i,
   input wire logic [2:0] cmd_bank_i,
   input wire logic [31:0] tim_i,
   // Memory clock and what the memories observed
   output logic memory_clock_o,
   output int edge_cnt_o,
   output int viol_o
);
   timeunit 1ns;
   timeprecision 1ns;

   int act_e[8], wr_e[8], rc_v[8], ras_v[8], wr_v[8];
   int last_act, last_bank, rrd_v, last_wr, wtr_v;

   // Free running clock, phase unrelated to clk_i
   initial begin
      memory_clock_o = 1'b0;
      #137;
      forever #200 memory_clock_o = ~memory_clock_o;
   end

   // Spacings are counted in memory clock edges
   always @(posedge memory_clock_o) edge_cnt_o <= edge_cnt_o + 1;

   // Spacing check of activate, precharge and read commands; each spacing keeps the value it started with
   always @(posedge clk_i) begin
      int e;
      int b;
      e = edge_cnt_o;
      b = int'(cmd_bank_i);
      if (rst_i) begin
         viol_o <= 0;
         last_act <= -1000;
         last_wr <= -1000;
         last_bank <= -1;
         for (int k = 0; k < 8; k++) begin
            act_e[k] <= -1000;
            wr_e[k] <= -1000;
         end
      end else if (cmd_issue_i) begin
         case (cmd_type_i)
            CMD_ACTIVATE: begin
               if (e - act_e[b] <= rc_v[b]) viol_o <= viol_o + 1;
               if (b != last_bank && e - last_act <= rrd_v) viol_o <= viol_o + 1;
               act_e[b] <= e;
               last_act <= e;
               last_bank <= b;
               rc_v[b] <= int'(tim_i[RC_MSB:RC_LSB]);
               ras_v[b] <= int'(tim_i[RAS_MSB:RAS_LSB]);
               rrd_v <= int'(tim_i[RRD_MSB:RRD_LSB]);
            end
            CMD_PRECHARGE: begin
               if (e - wr_e[b] <= wr_v[b]) viol_o <= viol_o + 1;
               if (e - act_e[b] <= ras_v[b]) viol_o <= viol_o + 1;
            end
            CMD_READ: if (e - last_wr <= wtr_v) viol_o <= viol_o + 1;
            default: begin
               wr_e[b] <= e;
               last_wr <= e;
               wr_v[b] <= int'(tim_i[WR_MSB:WR_LSB]);
               wtr_v <= int'(tim_i[WTR_MSB:WTR_LSB]);
            end
         endcase
      end
   end
endmodule // ddr_memory_model

// ===== verification/ddr_timing_one_tb.sv
module ddr_timing_one_tb
   import ddr_timing_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic clk, rst, cyc, stb, we, valid, ack, issue, mclk;
   logic [7:0] adr;
   logic [3:0] sel;
   logic [31:0] wdat, dat_o, rdat, tim, nxt, d, old;
   logic [2:0] cbank, bank_o;
   mem_cmd_t ctype, type_o;
   int edge_cnt, viol, fail_count, n_compared, a, b, n;
   int e[6];

   ddr_timing_one i_ddr_timing_one (.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .memory_clock_i(mclk), .cmd_valid_i(valid), .cmd_type_i(ctype),
      .cmd_bank_i(cbank), .cmd_issue_o(issue), .cmd_type_o(type_o), .cmd_bank_o(bank_o));

   ddr_memory_model i_ddr_memory_model (.clk_i(clk), .rst_i(rst), .cmd_issue_i(issue),
      .cmd_type_i(type_o), .cmd_bank_i(bank_o), .tim_i(tim), .memory_clock_o(mclk),
      .edge_cnt_o(edge_cnt), .viol_o(viol));

   // System clock, 50 ns
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Verdict and end of run
   task automatic tally_and_finish();
      if (fail_count == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   // Compare of a register or command value
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         $display("CHECK FAILED at %0t: got %0h expected %0h", $time, got, exp);
         fail_count++;
      end
   endtask

   // Compare of a memory clock edge number
   task automatic chk_edge(input int got, input int exp);
      n_compared++;
      if (got != exp) begin
         $display("CHECK FAILED at %0t: edge %0h expected %0h", $time, got, exp);
         fail_count++;
      end
   endtask

   // One classic Wishbone cycle, held until ack
   task automatic wb(input logic w, input logic [7:0] ad, input logic [3:0] s,
                     input logic [31:0] dd);
      int k;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= ad;
      sel <= s;
      wdat <= dd;
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (ack !== 1'b1 && k < 50);
      if (ack !== 1'b1) begin
         fail_count++;
         tally_and_finish();
      end
      rdat = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge clk);
   endtask

   // Request a command, hold it until issued, note its memory clock edge
   task automatic cmd(input mem_cmd_t t, input int bk, input int idx);
      int k;
      valid <= 1'b1;
      ctype <= t;
      cbank <= 3'(bk);
      k = 0;
      do begin
         @(posedge clk);
         k++;
      end while (issue !== 1'b1 && k < 3000);
      if (issue !== 1'b1) begin
         fail_count++;
         tally_and_finish();
      end
      e[idx] = edge_cnt;
      chk({27'h0, type_o, bank_o}, {27'h0, t, 3'(bk)});
      valid <= 1'b0;
      @(posedge clk);
   endtask

   // Spacing of a field: value plus one
   function automatic int sp(input logic [31:0] v, input int msb, input int lsb);
      return int'((v >> lsb) & ((32'h1 << (msb - lsb + 1)) - 1)) + 1;
   endfunction

   function automatic int mx(input int x, input int y);
      return (x > y) ? x : y;
   endfunction

   // Status just after a write that followed an activate one edge earlier
   function automatic logic [31:0] exp_status(input logic [31:0] v, input int bk);
      logic [31:0] s;
      s = 32'h0;
      s[STAT_RRD_BIT] = sp(v, RRD_MSB, RRD_LSB) > 2;
      s[STAT_WTR_BIT] = sp(v, WTR_MSB, WTR_LSB) > 1;
      s[STAT_BANK_LSB + bk] = sp(v, WR_MSB, WR_LSB) > 1 || sp(v, RAS_MSB, RAS_LSB) > 2;
      return s;
   endfunction

   // Main sequence
   initial begin
      void'($urandom(32'h9EF7));
      {rst, cyc, stb, we, valid, adr, sel, wdat, cbank} = {1'b1, 51'h0};
      ctype = CMD_ACTIVATE;
      tim = TIM_ONE_RESET;
      fail_count = 0;
      n_compared = 0;
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      wb(1'b0, TIM_ONE_OFFSET, 4'hF, 32'h0);
      chk(rdat, TIM_ONE_RESET);
      wb(1'b0, 8'h08, 4'hF, 32'h0);
      chk(rdat, 32'h0);
      d = $urandom;
      wb(1'b1, TIM_ONE_OFFSET, 4'hC, d);
      wb(1'b0, TIM_ONE_OFFSET, 4'hF, 32'h0);
      chk(rdat, (TIM_ONE_RESET & 32'h0000_FFFF) | (d & 32'h3FFF_0000));
      tim = 32'h0;
      for (int i = 0; i < 10; i++) begin
         nxt = (i == 0) ? 32'hFFFF_FFFF : $urandom;
         wb(1'b1, TIM_ONE_OFFSET, 4'hF, tim);
         wb(1'b0, TIM_ONE_OFFSET, 4'hF, 32'h0);
         chk(rdat, tim & TIM_ONE_WMASK);
         a = i % 8;
         b = (i + 3) % 8;
         cmd(CMD_ACTIVATE, a, 0);
         cmd(CMD_WRITE, a, 1);
         chk_edge(e[1], e[0] + 1);
         wb(1'b0, STATUS_OFFSET, 4'hF, 32'h0);
         chk(rdat, exp_status(tim, a));
         cmd(CMD_READ, a, 2);
         chk_edge(e[2], e[1] + sp(tim, WTR_MSB, WTR_LSB));
         cmd(CMD_PRECHARGE, a, 3);
         n = mx(e[1] + sp(tim, WR_MSB, WR_LSB), e[0] + sp(tim, RAS_MSB, RAS_LSB));
         chk_edge(e[3], mx(e[2] + 1, n));
         // Rewrite while spacings run: old values must finish
         wb(1'b1, TIM_ONE_OFFSET, 4'hF, nxt);
         old = tim;
         tim = nxt;
         cmd(CMD_ACTIVATE, b, 4);
         chk_edge(e[4], mx(e[3] + 1, e[0] + sp(old, RRD_MSB, RRD_LSB)));
         cmd(CMD_ACTIVATE, a, 5);
         n = mx(e[0] + sp(old, RC_MSB, RC_LSB), e[4] + sp(nxt, RRD_MSB, RRD_LSB));
         chk_edge(e[5], mx(e[4] + 1, n));
         n = 0;
         while (edge_cnt < e[5] + 258 && n < 4000) begin
            @(posedge clk);
            n++;
         end
         if (edge_cnt < e[5] + 258) begin
            fail_count++;
            tally_and_finish();
         end
      end
      chk_edge(viol, 0);
      tally_and_finish();
   end
endmodule // ddr_timing_one_tb
